// ---- four_level_interrupt_controller.sv ----
// Four-level interrupt controller: enables, priorities, nesting and vector offer.
// Assumes peripheral requests are levels on CLK, ext pins are asynchronous and
// active low, and the core answers an offer with a one-cycle take pulse.
//
// Behaviour
// - Eleven sources: two pins, three timers, serial, SPI, TWI, keyboard, USB, counter array.
// - Each source has its own enable bit; disabled sources never get serviced.
// - Primary enable bit 7 is a global enable; zero blocks all service.
// - Primary enable bit 6 gates the counter array interrupt.
// - Timer enables sit at primary bits 5, 3 and 1 for timers 2, 1, 0.
// - Serial port enable is primary enable bit 4.
// - External input enables: bit 2 for input one, bit 0 for input zero.
// - Primary enable register at A8h, resets to zero, single-bit access supported.
// - Priority level is high bit and low bit pair, 00 lowest, 11 highest.
// - Low priority register at B8h, bits 6..0 per source, bit 7 reserved.
// - Higher level preempts a running lower handler; same level is blocked.
// - A running highest-level handler blocks every other request until done.
// - Simultaneous requests of different levels: the higher level is serviced first.
// - Same-level simultaneous requests are chosen by a fixed polling order.
// - Vectors: counter array 0033h, keyboard 003Bh, SPI 004Bh.
// - Reset vector 0000h order 0; ext zero 0003h order 1; timer 0 000Bh order 2.
// - High priority register at B7h, same layout, resets zero, no bit access.
// - Secondary enable at B1h: USB bit 6, SPI 2, TWI 1, keyboard 0.
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none

module four_level_interrupt_controller (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [intc_pkg::WB_AW-1:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [intc_pkg::WB_DW-1:0] DAT_I,
  output logic [intc_pkg::WB_DW-1:0] DAT_O,
  output logic ACK_O,
  // Interrupt sources
  input wire logic EXT_IRQ_PIN_ZERO_N,
  input wire logic EXT_IRQ_PIN_ONE_N,
  input wire intc_pkg::periph_req_s PERIPH_REQ,
  // Core side
  output intc_pkg::core_offer_s CORE_OFFER,
  input wire intc_pkg::core_reply_s CORE_REPLY,
  // Event interrupt
  output logic IRQ
);

  typedef enum logic [1:0] {OFFER_IDLE, OFFER_SHOWN, OFFER_SETTLE} offer_state_e;

  // Picks the bit of one source out of a primary/secondary register pair
  function automatic logic src_bit(input logic [intc_pkg::REG_W-1:0] prim,
                                   input logic [intc_pkg::REG_W-1:0] sec, input int s);
    logic r;
    r = intc_pkg::SRC_IN_SECONDARY[s] ? sec[intc_pkg::SRC_BIT_POS[s]]
                                      : prim[intc_pkg::SRC_BIT_POS[s]];
    return r;
  endfunction

  // Register write with byte lane 0 and a writable-bit mask
  function automatic logic [intc_pkg::REG_W-1:0] reg_write(
      input logic [intc_pkg::REG_W-1:0] old, input logic [intc_pkg::REG_W-1:0] d,
      input logic [intc_pkg::REG_W-1:0] wmask);
    logic [intc_pkg::REG_W-1:0] r;
    r = (old & ~wmask) | (d & wmask);
    return r;
  endfunction

  logic [intc_pkg::REG_W-1:0] ien_prim_ff;
  logic [intc_pkg::REG_W-1:0] prio_low_prim_ff;
  logic [intc_pkg::REG_W-1:0] prio_high_prim_ff;
  logic [intc_pkg::REG_W-1:0] ien_sec_ff;
  logic [intc_pkg::REG_W-1:0] prio_low_sec_ff;
  logic [intc_pkg::REG_W-1:0] prio_high_sec_ff;
  logic [intc_pkg::EVT_W-1:0] evt_status_ff;
  logic [intc_pkg::EVT_W-1:0] evt_mask_ff;
  logic [intc_pkg::NUM_LEVELS-1:0] in_service_ff;
  logic [1:0] ext0_sync_ff;
  logic [1:0] ext1_sync_ff;
  offer_state_e offer_state_ff;
  offer_state_e nxt_offer_state;
  intc_pkg::core_offer_s offer_ff;
  intc_pkg::core_offer_s nxt_offer;
  logic ack_ff;
  logic [intc_pkg::WB_DW-1:0] dat_ff;
  logic irq_ff;

  logic [intc_pkg::REG_W-1:0] wdata;
  logic [intc_pkg::IDX_W-1:0] idx;
  logic bus_req;
  logic wr_lane0;
  logic [intc_pkg::NUM_SRC-1:0] src_req;
  logic [intc_pkg::NUM_SRC-1:0] src_en;
  logic [intc_pkg::NUM_SRC-1:0] active;
  logic [intc_pkg::LVL_W-1:0] src_lvl [intc_pkg::NUM_SRC];
  logic win_found;
  logic [intc_pkg::LVL_W-1:0] win_lvl;
  logic [intc_pkg::SRC_IDX_W-1:0] win_src;
  logic any_service;
  logic [intc_pkg::LVL_W-1:0] top_lvl;
  logic eligible;
  logic take_ok;
  logic [intc_pkg::NUM_LEVELS-1:0] service_after_done;
  logic [intc_pkg::EVT_W-1:0] evt_set;
  logic [intc_pkg::REG_W-1:0] rd_byte;

  assign idx = ADR_I[intc_pkg::WB_AW-1:2];
  assign bus_req = CYC_I && STB_I && !ack_ff;
  assign wr_lane0 = bus_req && WE_I && SEL_I[0];
  assign wdata = DAT_I[intc_pkg::REG_W-1:0];

  // Pins are asynchronous: two flops before anything looks at them
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ext0_sync_ff <= 2'h0;
      ext1_sync_ff <= 2'h0;
    end else begin
      ext0_sync_ff <= {ext0_sync_ff[0], !EXT_IRQ_PIN_ZERO_N};
      ext1_sync_ff <= {ext1_sync_ff[0], !EXT_IRQ_PIN_ONE_N};
    end
  end

  // Requests gathered in polling order
  always_comb begin
    src_req = '0;
    src_req[intc_pkg::SRC_EXT0] = ext0_sync_ff[1];
    src_req[intc_pkg::SRC_TIMER0] = PERIPH_REQ.timer0;
    src_req[intc_pkg::SRC_EXT1] = ext1_sync_ff[1];
    src_req[intc_pkg::SRC_TIMER1] = PERIPH_REQ.timer1;
    src_req[intc_pkg::SRC_SERIAL] = PERIPH_REQ.serial;
    src_req[intc_pkg::SRC_TIMER2] = PERIPH_REQ.timer2;
    src_req[intc_pkg::SRC_COUNTER_ARRAY] = PERIPH_REQ.counter_array;
    src_req[intc_pkg::SRC_KEYBOARD] = PERIPH_REQ.keyboard;
    src_req[intc_pkg::SRC_TWI] = PERIPH_REQ.twi;
    src_req[intc_pkg::SRC_SPI] = PERIPH_REQ.spi;
    src_req[intc_pkg::SRC_USB] = PERIPH_REQ.usb;
  end

  // Enable and level per source
  for (genvar s = 0; s < intc_pkg::NUM_SRC; s++) begin : g_src
    // Bit positions come from the source table
    assign src_en[s] = src_bit(ien_prim_ff, ien_sec_ff, s);
    assign src_lvl[s] = {src_bit(prio_high_prim_ff, prio_high_sec_ff, s),
                         src_bit(prio_low_prim_ff, prio_low_sec_ff, s)};
    assign active[s] = src_req[s] && src_en[s] && ien_prim_ff[intc_pkg::GLOBAL_EN_BIT];
  end

  // Highest level wins; on a tie the lowest polling number is kept
  always_comb begin
    win_found = 1'b0;
    win_lvl = '0;
    win_src = '0;
    for (int i = 0; i < intc_pkg::NUM_SRC; i++) begin
      if (active[i] && (!win_found || src_lvl[i] > win_lvl)) begin
        win_found = 1'b1;
        win_lvl = src_lvl[i];
        win_src = intc_pkg::SRC_IDX_W'(i);
      end
    end
  end

  // Highest level currently in service
  always_comb begin
    any_service = |in_service_ff;
    top_lvl = '0;
    for (int l = 0; l < intc_pkg::NUM_LEVELS; l++) begin
      if (in_service_ff[l]) begin
        top_lvl = intc_pkg::LVL_W'(l);
      end
    end
  end

  // Only a strictly higher level may interrupt; level 3 blocks everything
  assign eligible = win_found && (!any_service || win_lvl > top_lvl);

  assign take_ok = (offer_state_ff == OFFER_SHOWN) && CORE_REPLY.take;

  // Return clears the newest (highest) level, uncovering the one it preempted
  always_comb begin
    service_after_done = in_service_ff;
    if (CORE_REPLY.done && any_service) begin
      service_after_done[top_lvl] = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      in_service_ff <= '0;
    end else if (take_ok) begin
      in_service_ff <= service_after_done | (intc_pkg::NUM_LEVELS'(1) << offer_ff.level);
    end else begin
      in_service_ff <= service_after_done;
    end
  end

  // Offer sequencing; a settle cycle lets the new in-service level take effect
  always_comb begin
    nxt_offer_state = offer_state_ff;
    nxt_offer = offer_ff;
    unique case (offer_state_ff)
      OFFER_IDLE: begin
        if (eligible) begin
          nxt_offer_state = OFFER_SHOWN;
          nxt_offer.valid = 1'b1;
          nxt_offer.level = win_lvl;
          nxt_offer.source = win_src;
          nxt_offer.vector = intc_pkg::SRC_VECTOR[win_src];
        end
      end
      OFFER_SHOWN: begin
        if (CORE_REPLY.take) begin
          nxt_offer_state = OFFER_SETTLE;
          nxt_offer.valid = 1'b0;
        end else if (!eligible) begin
          nxt_offer_state = OFFER_IDLE;
          nxt_offer.valid = 1'b0;
        end else begin
          // A better request arriving before the take replaces the offer
          nxt_offer.level = win_lvl;
          nxt_offer.source = win_src;
          nxt_offer.vector = intc_pkg::SRC_VECTOR[win_src];
        end
      end
      OFFER_SETTLE: begin
        nxt_offer_state = OFFER_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      offer_state_ff <= OFFER_IDLE;
      offer_ff <= '{valid: 1'b0, level: '0, source: '0,
                    vector: intc_pkg::RESET_VECTOR};
    end else begin
      offer_state_ff <= nxt_offer_state;
      offer_ff <= nxt_offer;
    end
  end

  // Primary enable: full byte write plus set and clear aliases for bit access
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ien_prim_ff <= intc_pkg::RST_REG;
    end else if (wr_lane0) begin
      if (idx == intc_pkg::IDX_IEN_PRIMARY) begin
        ien_prim_ff <= reg_write(ien_prim_ff, wdata, intc_pkg::WMASK_IEN_PRIMARY);
      end else if (idx == intc_pkg::IDX_IEN_PRIMARY_SET) begin
        ien_prim_ff <= ien_prim_ff | wdata;
      end else if (idx == intc_pkg::IDX_IEN_PRIMARY_CLR) begin
        ien_prim_ff <= ien_prim_ff & ~wdata;
      end
    end
  end

  // Primary low priority, bit 7 reserved
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      prio_low_prim_ff <= intc_pkg::RST_REG;
    end else if (wr_lane0) begin
      if (idx == intc_pkg::IDX_PRIO_LOW_PRIMARY) begin
        prio_low_prim_ff <= reg_write(prio_low_prim_ff, wdata,
                                      intc_pkg::WMASK_PRIO_PRIMARY);
      end else if (idx == intc_pkg::IDX_PRIO_LOW_PRIMARY_SET) begin
        prio_low_prim_ff <= prio_low_prim_ff | (wdata & intc_pkg::WMASK_PRIO_PRIMARY);
      end else if (idx == intc_pkg::IDX_PRIO_LOW_PRIMARY_CLR) begin
        prio_low_prim_ff <= prio_low_prim_ff & ~wdata;
      end
    end
  end

  // Primary high priority: byte access only
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      prio_high_prim_ff <= intc_pkg::RST_REG;
    end else if (wr_lane0 && idx == intc_pkg::IDX_PRIO_HIGH_PRIMARY) begin
      prio_high_prim_ff <= reg_write(prio_high_prim_ff, wdata,
                                     intc_pkg::WMASK_PRIO_PRIMARY);
    end
  end

  // Secondary enable and priorities
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ien_sec_ff <= intc_pkg::RST_REG;
      prio_low_sec_ff <= intc_pkg::RST_REG;
      prio_high_sec_ff <= intc_pkg::RST_REG;
    end else if (wr_lane0) begin
      if (idx == intc_pkg::IDX_IEN_SECONDARY) begin
        ien_sec_ff <= reg_write(ien_sec_ff, wdata, intc_pkg::WMASK_SECONDARY);
      end
      if (idx == intc_pkg::IDX_PRIO_LOW_SECONDARY) begin
        prio_low_sec_ff <= reg_write(prio_low_sec_ff, wdata, intc_pkg::WMASK_SECONDARY);
      end
      if (idx == intc_pkg::IDX_PRIO_HIGH_SECONDARY) begin
        prio_high_sec_ff <= reg_write(prio_high_sec_ff, wdata, intc_pkg::WMASK_SECONDARY);
      end
    end
  end

  // Events: vector taken, taken while nested, return with nothing in service
  always_comb begin
    evt_set = '0;
    evt_set[intc_pkg::EVT_TAKEN] = take_ok;
    evt_set[intc_pkg::EVT_PREEMPT] = take_ok && any_service;
    evt_set[intc_pkg::EVT_STRAY_RETURN] = CORE_REPLY.done && !any_service;
  end

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      evt_status_ff <= intc_pkg::RST_EVT;
    end else if (wr_lane0 && idx == intc_pkg::IDX_EVT_STATUS) begin
      evt_status_ff <= (evt_status_ff & ~wdata[intc_pkg::EVT_W-1:0]) | evt_set;
    end else begin
      evt_status_ff <= evt_status_ff | evt_set;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      evt_mask_ff <= intc_pkg::RST_EVT;
    end else if (wr_lane0 && idx == intc_pkg::IDX_EVT_MASK) begin
      evt_mask_ff <= wdata[intc_pkg::EVT_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(evt_status_ff & evt_mask_ff);
    end
  end

  // Read mux; unmapped and reserved bits read zero
  always_comb begin
    rd_byte = '0;
    unique case (idx)
      intc_pkg::IDX_IEN_PRIMARY: rd_byte = ien_prim_ff;
      intc_pkg::IDX_PRIO_LOW_PRIMARY: rd_byte = prio_low_prim_ff;
      intc_pkg::IDX_PRIO_HIGH_PRIMARY: rd_byte = prio_high_prim_ff;
      intc_pkg::IDX_IEN_SECONDARY: rd_byte = ien_sec_ff;
      intc_pkg::IDX_PRIO_LOW_SECONDARY: rd_byte = prio_low_sec_ff;
      intc_pkg::IDX_PRIO_HIGH_SECONDARY: rd_byte = prio_high_sec_ff;
      intc_pkg::IDX_EVT_STATUS: rd_byte = intc_pkg::REG_W'(evt_status_ff);
      intc_pkg::IDX_EVT_MASK: rd_byte = intc_pkg::REG_W'(evt_mask_ff);
      intc_pkg::IDX_SERVICE: rd_byte = {3'h0, offer_ff.valid, in_service_ff};
      intc_pkg::IDX_VECTOR_LO: rd_byte = offer_ff.vector[7:0];
      intc_pkg::IDX_VECTOR_HI: rd_byte = offer_ff.vector[15:8];
      default: rd_byte = '0;
    endcase
  end

  // One-cycle ack to every access, mapped or not
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ack_ff <= 1'b0;
      dat_ff <= '0;
    end else begin
      ack_ff <= bus_req;
      if (bus_req && !WE_I) begin
        dat_ff <= intc_pkg::WB_DW'(rd_byte);
      end
    end
  end

  assign ACK_O = ack_ff;
  assign DAT_O = dat_ff;
  assign CORE_OFFER = offer_ff;
  assign IRQ = irq_ff;

endmodule // four_level_interrupt_controller

`default_nettype wire

// ---- intc_pkg.sv ----
// Constants, register map and carriers for the four-level interrupt controller.
// Assumes a 32-bit classic Wishbone slave port and a CPU core on the same clock.
package intc_pkg;

  localparam int NUM_SRC = 11;
  localparam int NUM_LEVELS = 4;
  localparam int REG_W = 8;
  localparam int VEC_W = 16;
  localparam int SRC_IDX_W = 4;
  localparam int LVL_W = 2;
  localparam int EVT_W = 3;
  localparam int WB_DW = 32;
  localparam int WB_AW = 12;
  localparam int IDX_W = 10;

  // Register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_IEN_PRIMARY = 10'h0a8;
  localparam logic [IDX_W-1:0] IDX_PRIO_LOW_PRIMARY = 10'h0b8;
  localparam logic [IDX_W-1:0] IDX_PRIO_HIGH_PRIMARY = 10'h0b7;
  localparam logic [IDX_W-1:0] IDX_IEN_SECONDARY = 10'h0b1;
  localparam logic [IDX_W-1:0] IDX_PRIO_LOW_SECONDARY = 10'h0b2;
  localparam logic [IDX_W-1:0] IDX_PRIO_HIGH_SECONDARY = 10'h0b3;
  localparam logic [IDX_W-1:0] IDX_EVT_STATUS = 10'h0c0;
  localparam logic [IDX_W-1:0] IDX_EVT_MASK = 10'h0c1;
  localparam logic [IDX_W-1:0] IDX_SERVICE = 10'h0c2;
  localparam logic [IDX_W-1:0] IDX_VECTOR_LO = 10'h0c3;
  localparam logic [IDX_W-1:0] IDX_VECTOR_HI = 10'h0c4;
  localparam logic [IDX_W-1:0] IDX_IEN_PRIMARY_SET = 10'h0c8;
  localparam logic [IDX_W-1:0] IDX_IEN_PRIMARY_CLR = 10'h0c9;
  localparam logic [IDX_W-1:0] IDX_PRIO_LOW_PRIMARY_SET = 10'h0ca;
  localparam logic [IDX_W-1:0] IDX_PRIO_LOW_PRIMARY_CLR = 10'h0cb;

  // Reset values and writable bits
  localparam logic [REG_W-1:0] RST_REG = 8'h00;
  localparam logic [REG_W-1:0] WMASK_IEN_PRIMARY = 8'hff;
  localparam logic [REG_W-1:0] WMASK_PRIO_PRIMARY = 8'h7f;
  localparam logic [REG_W-1:0] WMASK_SECONDARY = 8'h47;
  localparam logic [EVT_W-1:0] RST_EVT = 3'h0;
  localparam logic [VEC_W-1:0] RESET_VECTOR = 16'h0000;

  localparam int GLOBAL_EN_BIT = 7;
  localparam int EVT_TAKEN = 0;
  localparam int EVT_PREEMPT = 1;
  localparam int EVT_STRAY_RETURN = 2;

  // Source numbering is the polling order within a level, first wins
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TIMER0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TIMER1 = 3;
  localparam int SRC_SERIAL = 4;
  localparam int SRC_TIMER2 = 5;
  localparam int SRC_COUNTER_ARRAY = 6;
  localparam int SRC_KEYBOARD = 7;
  localparam int SRC_TWI = 8;
  localparam int SRC_SPI = 9;
  localparam int SRC_USB = 10;

  // Per source: 1 when its bits live in the secondary registers, and the bit used
  localparam logic SRC_IN_SECONDARY [NUM_SRC] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1};
  localparam int SRC_BIT_POS [NUM_SRC] = '{0, 1, 2, 3, 4, 5, 6, 0, 1, 2, 6};
  localparam logic [VEC_W-1:0] SRC_VECTOR [NUM_SRC] = '{
    16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
    16'h0033, 16'h003b, 16'h0043, 16'h004b, 16'h0053};

  typedef struct packed {
    logic timer0;
    logic timer1;
    logic timer2;
    logic serial;
    logic counter_array;
    logic keyboard;
    logic twi;
    logic spi;
    logic usb;
  } periph_req_s;

  typedef struct packed {
    logic valid;
    logic [LVL_W-1:0] level;
    logic [SRC_IDX_W-1:0] source;
    logic [VEC_W-1:0] vector;
  } core_offer_s;

  typedef struct packed {
    logic take;
    logic done;
  } core_reply_s;

endpackage

// ---- intc_chk_asserts.sv ----
// Checker for bus answers, vector offers and the event line of the controller.
// Bound to the controller's top module; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module intc_chk (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Bus
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic ACK_O,
  input wire logic [intc_pkg::WB_DW-1:0] DAT_O,
  // Core link and event line
  input wire intc_pkg::core_offer_s CORE_OFFER,
  input wire intc_pkg::core_reply_s CORE_REPLY,
  input wire logic IRQ
);
  logic [3:0] busy_ff;
  logic [3:0] nxt_busy;
  // In-service mirror: done drops the top level before take adds one
  always_comb begin
    nxt_busy = busy_ff;
    for (int i = 0; i < 4; i++) begin
      if (CORE_REPLY.done && busy_ff[i] && (busy_ff >> (i + 1)) == 4'h0) nxt_busy[i] = 1'b0;
    end
    if (CORE_REPLY.take && CORE_OFFER.valid) nxt_busy[CORE_OFFER.level] = 1'b1;
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) busy_ff <= 4'h0;
    else busy_ff <= nxt_busy;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence s_bus_req;
    CYC_I && STB_I && !ACK_O;
  endsequence
  sequence s_settle;
    !CORE_OFFER.valid [*2];
  endsequence
  property p_ack_next;
    s_bus_req |=> ACK_O;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not answered");
  property p_ack_pulse;
    ACK_O |=> !ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
  property p_ack_cause;
    !(CYC_I && STB_I) |=> !ACK_O;
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_byte;
    ACK_O |-> DAT_O[31:8] == 24'h0;
  endproperty
  a_dat_byte: assert property (p_dat_byte) else $error("read data above byte");
  property p_vec_map;
    CORE_OFFER.valid |-> CORE_OFFER.source < 4'hb &&
      CORE_OFFER.vector == intc_pkg::SRC_VECTOR[CORE_OFFER.source];
  endproperty
  a_vec_map: assert property (p_vec_map) else $error("vector mismatch");
  property p_take_settle;
    CORE_OFFER.valid && CORE_REPLY.take |=> s_settle;
  endproperty
  a_take_settle: assert property (p_take_settle) else $error("offer not withdrawn");
  property p_above_busy;
    CORE_OFFER.valid |-> (busy_ff >> CORE_OFFER.level) == 4'h0;
  endproperty
  a_above_busy: assert property (p_above_busy) else $error("offer not above service");
  // Only a bus write may clear a sticky event
  property p_irq_hold;
    IRQ && !(CYC_I && STB_I) |=> IRQ;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("event line dropped alone");
endmodule // intc_chk
bind four_level_interrupt_controller intc_chk i_intc_chk (.CLK, .RESETN, .CYC_I, .STB_I, .ACK_O,
  .DAT_O, .CORE_OFFER, .CORE_REPLY, .IRQ);
`default_nettype wire

// ---- core_model.sv ----
// CPU core model: takes shown vectors after a set delay, signals returns on command.
// Assumes the controller's clock and reset.
`timescale 1ns/100ps
`default_nettype none
module core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Controller side
  input wire intc_pkg::core_offer_s offer,
  output var intc_pkg::core_reply_s reply,
  // Bench controls
  input wire logic auto_take,
  input wire logic [3:0] take_wait,
  input wire logic do_done,
  output logic [15:0] taken_vec
);
  logic [3:0] wait_ff;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wait_ff <= 4'h0;
      reply <= '0;
      taken_vec <= 16'h0;
    end else begin
      reply.done <= do_done;
      reply.take <= 1'b0;
      // Offer may still change while shown; keep what is taken
      if (reply.take && offer.valid) taken_vec <= offer.vector;
      if (offer.valid && auto_take && !reply.take) begin
        if (wait_ff >= take_wait) begin
          reply.take <= 1'b1;
          wait_ff <= 4'h0;
        end else begin
          wait_ff <= wait_ff + 4'h1;
        end
      end else begin
        wait_ff <= 4'h0;
      end
    end
  end
endmodule // core_model
`default_nettype wire

// ---- four_level_interrupt_controller_tb.sv ----
// Self-checking bench for the four-level interrupt controller.
// Assumes the core model on the vector link and a 250 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module four_level_interrupt_controller_tb;
  logic clk, resetn, cyc, stb, we, ack, irq, auto_take, do_done;
  logic [11:0] adr;
  logic [3:0] sel, take_wait;
  logic [31:0] dat_w, dat_r, rdata;
  logic [10:0] src;
  logic [15:0] taken_vec;
  intc_pkg::core_offer_s offer;
  intc_pkg::core_reply_s reply;
  int miscompares, tests_run;
  int ntake = 0;
  logic [15:0] vec_tab [11] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
    16'h0033, 16'h003b, 16'h0043, 16'h004b, 16'h0053};
  int en_pos [11] = '{0, 1, 2, 3, 4, 5, 6, 0, 1, 2, 6};
  int ord [4] = '{2, 1, 0, 4};
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (reply.take && offer.valid) ntake <= ntake + 1;
  four_level_interrupt_controller i_four_level_interrupt_controller (.CLK(clk), .RESETN(resetn),
    .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r),
    .ACK_O(ack), .EXT_IRQ_PIN_ZERO_N(~src[0]), .EXT_IRQ_PIN_ONE_N(~src[2]),
    .PERIPH_REQ({src[1], src[3], src[5], src[4], src[6], src[7], src[8], src[9], src[10]}),
    .CORE_OFFER(offer), .CORE_REPLY(reply), .IRQ(irq));
  core_model i_core_model (.clk(clk), .resetn(resetn), .offer(offer), .reply(reply),
    .auto_take(auto_take), .take_wait(take_wait), .do_done(do_done), .taken_vec(taken_vec));
  task automatic close_out;
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_irq(input logic e);
    @(posedge clk);
    tests_run++;
    if (irq !== e) begin
      miscompares++;
      $display("BAD %0t event line is %b", $time, irq);
    end
  endtask
  task automatic bus(input logic [9:0] idx, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we} <= {2'b11, w};
    adr <= {idx, 2'b00};
    dat_w <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdata = dat_r;
    {cyc, stb} <= 2'b00;
    if (ack !== 1'b1) begin
      miscompares++;
      $display("BAD %0t bus access not answered", $time);
      close_out();
    end
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d);
  endtask
  task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
    bus(idx, 1'b0, 8'h00);
    chk(rdata, {24'h0, exp});
  endtask
  // Waits for the core to take, then drops the handled request
  task automatic expect_take(input int s);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(reply.take === 1'b1 && offer.valid === 1'b1) && n < 40);
    @(posedge clk);
    src[s] <= 1'b0;
    chk({16'h0, taken_vec}, {16'h0, vec_tab[s]});
    if (n >= 40) begin
      miscompares++;
      $display("BAD %0t no vector taken", $time);
      close_out();
    end
  endtask
  task automatic quiet(input int c);
    int k;
    k = ntake;
    repeat (c) @(posedge clk);
    chk(ntake, k);
  endtask
  // Extra cycles let a released pin clear its synchroniser first
  task automatic done_pulse;
    repeat (2) @(posedge clk);
    do_done <= 1'b1;
    @(posedge clk);
    do_done <= 1'b0;
  endtask
  initial begin
    {resetn, cyc, stb, we, auto_take, do_done} = 6'b000010;
    {miscompares, tests_run} = {32'h0, 32'h0};
    {adr, sel, dat_w, src, take_wait} = {12'h0, 4'hf, 32'h0, 11'h0, 4'h0};
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rd(10'h0a8, 8'h00);
    rd(10'h0b8, 8'h00);
    rd(10'h0b7, 8'h00);
    rd(10'h0b1, 8'h00);
    wr(10'h0b8, 8'hff);
    rd(10'h0b8, 8'h7f);
    wr(10'h0b7, 8'hff);
    rd(10'h0b7, 8'h7f);
    wr(10'h0b1, 8'hff);
    rd(10'h0b1, 8'h47);
    rd(10'h3ff, 8'h00);
    wr(10'h0a8, 8'hff);
    wr(intc_pkg::IDX_IEN_PRIMARY_CLR, 8'h81);
    rd(10'h0a8, 8'h7e);
    wr(intc_pkg::IDX_IEN_PRIMARY_SET, 8'h01);
    rd(10'h0a8, 8'h7f);
    wr(intc_pkg::IDX_PRIO_LOW_PRIMARY_CLR, 8'h0f);
    rd(10'h0b8, 8'h70);
    wr(intc_pkg::IDX_PRIO_LOW_PRIMARY_SET, 8'h81);
    rd(10'h0b8, 8'h71);
    wr(10'h0b2, 8'hff);
    rd(10'h0b2, 8'h47);
    wr(10'h0b3, 8'hff);
    rd(10'h0b3, 8'h47);
    wr(10'h0b8, 8'h00);
    wr(10'h0b7, 8'h00);
    // Each source: own enable off, then global off, then served
    for (int s = 0; s < 11; s++) begin
      wr(10'h0a8, s < 7 ? 8'hff ^ (8'h01 << en_pos[s]) : 8'hff);
      wr(10'h0b1, s < 7 ? 8'h47 : 8'h47 ^ (8'h01 << en_pos[s]));
      src[s] <= 1'b1;
      quiet(8);
      wr(10'h0a8, 8'h7f);
      wr(10'h0b1, 8'h47);
      quiet(8);
      wr(10'h0a8, 8'hff);
      expect_take(s);
      done_pulse();
    end
    // Levels: ext0 0, timer0 1, ext1 2, timer1 3, serial 0
    wr(10'h0a8, 8'h9f);
    wr(10'h0b1, 8'h00);
    wr(10'h0b7, 8'h0c);
    wr(10'h0b8, 8'h0a);
    take_wait <= 4'h3;
    src <= 11'h001;
    expect_take(0);
    src[4] <= 1'b1;
    quiet(8);
    src[3] <= 1'b1;
    expect_take(3);
    rd(intc_pkg::IDX_SERVICE, 8'h09);
    src[2] <= 1'b1;
    quiet(8);
    done_pulse();
    expect_take(2);
    done_pulse();
    quiet(8);
    done_pulse();
    expect_take(4);
    done_pulse();
    auto_take <= 1'b0;
    src <= 11'h017;
    repeat (6) @(posedge clk);
    // Offer held untaken: the level 2 pin request must be on show
    rd(intc_pkg::IDX_VECTOR_LO, 8'h13);
    rd(intc_pkg::IDX_VECTOR_HI, 8'h00);
    rd(intc_pkg::IDX_SERVICE, 8'h10);
    auto_take <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      expect_take(ord[i]);
      done_pulse();
    end
    rd(intc_pkg::IDX_EVT_STATUS, 8'h03);
    wr(intc_pkg::IDX_EVT_MASK, 8'h01);
    chk_irq(1'b1);
    wr(intc_pkg::IDX_EVT_MASK, 8'h00);
    chk_irq(1'b0);
    wr(intc_pkg::IDX_EVT_MASK, 8'h07);
    wr(intc_pkg::IDX_EVT_STATUS, 8'h03);
    chk_irq(1'b0);
    done_pulse();
    rd(intc_pkg::IDX_EVT_STATUS, 8'h04);
    chk_irq(1'b1);
    close_out();
  end
endmodule // four_level_interrupt_controller_tb
`default_nettype wire
